// file: common/fault_check_defs.svh
`ifndef FAULT_CHECK_DEFS_SVH
`define FAULT_CHECK_DEFS_SVH

// register word indexes; byte address is four times the index
`define IDX_OV_CHECK_EN 6'h1a
`define IDX_UV_CHECK_EN 6'h1b
`define IDX_AUX_OV_CHECK_EN 6'h1c
`define IDX_CELL_ADC_ALERT 6'h20
`define IDX_CELL_CMP_ALERT 6'h21
`define IDX_CHAN_ALERT 6'h22
`define IDX_IRQ_STATUS 6'h23
`define IDX_IRQ_MASK 6'h24

`define ADDR_IDX_HI 7
`define ADDR_IDX_LO 2

`define CELL_COUNT 14
`define AUX_COUNT 4
`define MEAS_W 14
`define IRQ_W 6

// enable register fields
`define EN_CELL_HI 13
`define EN_CELL_LO 0
`define EN_BLOCK_BIT 14
`define EN_CSA_BIT 15
`define EN_REG_W 16
`define AUX_EN_HI 3
`define EN_RESET 16'h0000
`define AUX_EN_RESET 4'h0

// alert status layout: cell ov low half, cell uv high half
`define ALERT_UV_LO 16
`define CHAN_CSA_OV_BIT 0
`define CHAN_CSA_UV_BIT 1
`define CHAN_BLK_OV_BIT 2
`define CHAN_BLK_UV_BIT 3
`define CHAN_AUX_ADC_LO 4
`define CHAN_AUX_CMP_LO 8

// interrupt event bits
`define IRQ_CELL_OV 0
`define IRQ_CELL_UV 1
`define IRQ_CSA 2
`define IRQ_BLOCK 3
`define IRQ_AUX 4
`define IRQ_SCAN_DONE 5

// aux channels that share the two-wire bus mode
`define AUX_BUS_MODE_CHANS 4'h3

`endif

// file: common/fault_check_pkg.sv
`include "fault_check_defs.svh"

package fault_check_pkg;

   typedef enum logic [1:0] {
      KIND_CELL = 2'h0,
      KIND_CSA = 2'h1,
      KIND_BLOCK = 2'h2,
      KIND_AUX = 2'h3
   } meas_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_SCAN = 2'h2
   } scan_state_e;

   typedef struct packed {
      logic valid;
      logic from_cmp;
      meas_kind_e kind;
      logic [3:0] chan;
      logic [`MEAS_W-1:0] value;
   } meas_s;

   typedef struct packed {
      logic [`MEAS_W-1:0] cell_ov_adc_threshold;
      logic [`MEAS_W-1:0] cell_uv_adc_threshold;
      logic [`MEAS_W-1:0] cell_ov_comparator_threshold;
      logic [`MEAS_W-1:0] cell_uv_comparator_threshold;
      logic [`MEAS_W-1:0] current_amp_ov_threshold;
      logic [`MEAS_W-1:0] current_amp_uv_threshold;
      logic [`MEAS_W-1:0] block_ov_threshold;
      logic [`MEAS_W-1:0] block_uv_threshold;
      logic [`MEAS_W-1:0] aux_ratio_cold_adc_threshold;
      logic [`MEAS_W-1:0] aux_abs_cold_adc_threshold;
      logic [`MEAS_W-1:0] aux_ratio_cold_cmp_threshold;
      logic [`MEAS_W-1:0] aux_abs_cold_cmp_threshold;
   } thresh_s;

   typedef struct packed {
      logic [`AUX_COUNT-1:0] aux_reference_select;
      logic [`AUX_COUNT-1:0] aux_pin_io_mode_en;
      logic aux_bus_mode_en;
   } aux_cfg_s;

   typedef struct packed {
      logic [`CELL_COUNT-1:0] cell_ov_check_en;
      logic [`CELL_COUNT-1:0] cell_uv_check_en;
      logic current_amp_ov_check_en;
      logic current_amp_uv_check_en;
      logic block_ov_check_en;
      logic block_uv_check_en;
      logic [`AUX_COUNT-1:0] aux_cold_check_en;
   } enables_s;

   typedef struct packed {
      logic [`CELL_COUNT-1:0] cell_adc_ov;
      logic [`CELL_COUNT-1:0] cell_adc_uv;
      logic [`CELL_COUNT-1:0] cell_cmp_ov;
      logic [`CELL_COUNT-1:0] cell_cmp_uv;
      logic csa_ov;
      logic csa_uv;
      logic blk_ov;
      logic blk_uv;
      logic [`AUX_COUNT-1:0] aux_adc;
      logic [`AUX_COUNT-1:0] aux_cmp;
   } alerts_s;

   typedef struct packed {
      logic [`IRQ_W-1:0] status;
      logic [`IRQ_W-1:0] mask;
   } irq_state_s;

endpackage

// file: design/fault_compare.sv
`timescale 1ns/1ps
`include "fault_check_defs.svh"

module fault_compare
   import fault_check_pkg::*;
(
   input wire meas_s meas,
   input wire thresh_s thr,
   input wire enables_s en,
   input wire aux_cfg_s aux_cfg,
   output alerts_s hit
);

   function automatic logic [`CELL_COUNT-1:0] cell_select(input logic [3:0] chan);
      cell_select = '0;
      if (chan < 4'(`CELL_COUNT))
         cell_select[chan] = 1'b1;
   endfunction

   logic [`AUX_COUNT-1:0] aux_exceed_adc;
   logic [`AUX_COUNT-1:0] aux_exceed_cmp;
   logic [`AUX_COUNT-1:0] aux_live;
   logic [`AUX_COUNT-1:0] aux_sel;

   // pin-io mode, or bus mode on aux 1..0, masks the check; register still keeps its value
   assign aux_live = en.aux_cold_check_en & ~aux_cfg.aux_pin_io_mode_en &
                     ~(aux_cfg.aux_bus_mode_en ? `AUX_BUS_MODE_CHANS : 4'h0);
   assign aux_sel = (meas.chan < 4'(`AUX_COUNT)) ? 4'(4'h1 << meas.chan[1:0]) : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < `AUX_COUNT; gi++) begin : g_aux
         assign aux_exceed_adc[gi] = meas.value > (aux_cfg.aux_reference_select[gi] ?
            thr.aux_abs_cold_adc_threshold : thr.aux_ratio_cold_adc_threshold);
         assign aux_exceed_cmp[gi] = meas.value > (aux_cfg.aux_reference_select[gi] ?
            thr.aux_abs_cold_cmp_threshold : thr.aux_ratio_cold_cmp_threshold);
      end
   endgenerate

   always_comb begin
      logic [`CELL_COUNT-1:0] csel;
      csel = cell_select(meas.chan);
      hit = '0;
      if (meas.valid) begin
         case (meas.kind)
            KIND_CELL: begin
               if (meas.from_cmp) begin
                  hit.cell_cmp_ov = en.cell_ov_check_en & csel &
                     {`CELL_COUNT{meas.value > thr.cell_ov_comparator_threshold}};
                  hit.cell_cmp_uv = en.cell_uv_check_en & csel &
                     {`CELL_COUNT{meas.value < thr.cell_uv_comparator_threshold}};
               end else begin
                  hit.cell_adc_ov = en.cell_ov_check_en & csel &
                     {`CELL_COUNT{meas.value > thr.cell_ov_adc_threshold}};
                  hit.cell_adc_uv = en.cell_uv_check_en & csel &
                     {`CELL_COUNT{meas.value < thr.cell_uv_adc_threshold}};
               end
            end
            KIND_CSA: begin
               // comparator results for the amplifier are simply not checked
               if (!meas.from_cmp) begin
                  hit.csa_ov = en.current_amp_ov_check_en &&
                     meas.value > thr.current_amp_ov_threshold;
                  hit.csa_uv = en.current_amp_uv_check_en &&
                     meas.value < thr.current_amp_uv_threshold;
               end
            end
            KIND_BLOCK: begin
               if (!meas.from_cmp) begin
                  hit.blk_ov = en.block_ov_check_en &&
                     meas.value > thr.block_ov_threshold;
                  hit.blk_uv = en.block_uv_check_en &&
                     meas.value < thr.block_uv_threshold;
               end
            end
            KIND_AUX: begin
               if (meas.from_cmp)
                  hit.aux_cmp = aux_live & aux_sel & aux_exceed_cmp;
               else
                  hit.aux_adc = aux_live & aux_sel & aux_exceed_adc;
            end
            default: hit = '0;
         endcase
      end
   end

endmodule

// file: design/irq_status.sv
`timescale 1ns/1ps
`include "fault_check_defs.svh"

module irq_status
   import fault_check_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [`IRQ_W-1:0] event_in,
   input wire logic status_wr,
   input wire logic mask_wr,
   input wire logic [`IRQ_W-1:0] wdata,
   output logic [`IRQ_W-1:0] status,
   output logic [`IRQ_W-1:0] mask,
   output logic irq
);

   irq_state_s state_reg;
   irq_state_s state_next;

   always_comb begin
      state_next = state_reg;
      // write-one-to-clear, but a same-cycle event survives
      if (status_wr)
         state_next.status = state_reg.status & ~wdata;
      state_next.status = state_next.status | event_in;
      if (mask_wr)
         state_next.mask = wdata;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign status = state_reg.status;
   assign mask = state_reg.mask;
   assign irq = |(state_reg.status & state_reg.mask);

endmodule

// file: design/fault_check_enable_regs.sv
// Behaviour
// - Enabled amplifier overvoltage check flags ADC results above its threshold.
// - Amplifier checks use ADC results only; comparator results are ignored.
// - Writing zero to an amplifier enable clears that amplifier alert.
// - Enabled block overvoltage check flags block ADC results above threshold.
// - Enabled block undervoltage check flags block ADC results below threshold.
// - Writing zero to a block enable clears that block alert.
// - Cell overvoltage enables bits 13..0 check ADC and comparator thresholds.
// - Cell undervoltage enables bits 13..0 check ADC and comparator thresholds.
// - Writing zero to a cell enable clears its ADC and comparator alerts.
// - Aux cold enables bits 3..0; reference select picks ratiometric or absolute.
// - Writing zero to an aux enable clears that aux channel alert.
// - Aux enable ignored in pin-io mode, or bus mode for 1..0; reads back.
// - Enabled checks are applied during scans, on ADC path, and on comparator path for cell and aux checks.
`timescale 1ns/1ps
`include "fault_check_defs.svh"

module fault_check_enable_regs
   import fault_check_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`ADDR_IDX_HI:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic scan_start,
   input wire logic scan_end,
   input wire meas_s meas,
   input wire thresh_s thr,
   input wire aux_cfg_s aux_cfg,
   output alerts_s alerts,
   output logic scanning,
   output logic irq
);

   typedef struct packed {
      logic [`EN_REG_W-1:0] ov_en;
      logic [`EN_REG_W-1:0] uv_en;
      logic [`AUX_EN_HI:0] aux_en;
      enables_s snap;
      alerts_s alert;
      scan_state_e scan;
      logic ack;
      logic [31:0] rdata;
      logic scan_done;
   } state_s;

   state_s state_reg;
   state_s state_next;

   alerts_s hit;
   meas_s meas_gated;
   logic [`IRQ_W-1:0] irq_events;
   logic [`IRQ_W-1:0] irq_stat;
   logic [`IRQ_W-1:0] irq_mask;
   logic req;
   logic wr;
   logic [`ADDR_IDX_HI-`ADDR_IDX_LO:0] idx;
   logic [`EN_REG_W-1:0] lane_mask;
   logic irq_status_wr;
   logic irq_mask_wr;

   function automatic logic [`EN_REG_W-1:0] merge16(input logic [`EN_REG_W-1:0] cur,
                                                    input logic [`EN_REG_W-1:0] wd,
                                                    input logic [`EN_REG_W-1:0] lm);
      merge16 = (cur & ~lm) | (wd & lm);
   endfunction

   function automatic logic is_idx(input logic [`ADDR_IDX_HI-`ADDR_IDX_LO:0] a,
                                   input logic [`ADDR_IDX_HI-`ADDR_IDX_LO:0] b);
      is_idx = (a == b);
   endfunction

   // one access per request; ack drops the cycle after it is given
   assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
   assign wr = req && wb_we_i;
   assign idx = wb_adr_i[`ADDR_IDX_HI:`ADDR_IDX_LO];
   assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign irq_status_wr = wr && is_idx(idx, 6'(`IDX_IRQ_STATUS));
   assign irq_mask_wr = wr && is_idx(idx, 6'(`IDX_IRQ_MASK));

   // results outside a scan never reach the compare
   always_comb begin
      meas_gated = meas;
      meas_gated.valid = meas.valid && (state_reg.scan == ST_SCAN);
   end

   fault_compare u_compare (
      .meas(meas_gated),
      .thr(thr),
      .en(state_reg.snap),
      .aux_cfg(aux_cfg),
      .hit(hit)
   );

   always_comb begin
      logic [`EN_REG_W-1:0] new_ov;
      logic [`EN_REG_W-1:0] new_uv;
      logic [`AUX_EN_HI:0] new_aux;
      logic [`EN_REG_W-1:0] clr_ov;
      logic [`EN_REG_W-1:0] clr_uv;
      logic [`AUX_EN_HI:0] clr_aux;
      alerts_s clr;
      new_ov = state_reg.ov_en;
      new_uv = state_reg.uv_en;
      new_aux = state_reg.aux_en;
      clr_ov = '0;
      clr_uv = '0;
      clr_aux = '0;
      clr = '0;
      state_next = state_reg;
      state_next.ack = req;
      state_next.scan_done = 1'b0;

      if (wr && is_idx(idx, 6'(`IDX_OV_CHECK_EN))) begin
         new_ov = merge16(state_reg.ov_en, wb_dat_i[`EN_REG_W-1:0], lane_mask);
         clr_ov = ~new_ov & lane_mask;
      end
      if (wr && is_idx(idx, 6'(`IDX_UV_CHECK_EN))) begin
         new_uv = merge16(state_reg.uv_en, wb_dat_i[`EN_REG_W-1:0], lane_mask);
         clr_uv = ~new_uv & lane_mask;
      end
      // upper bits of the aux register are not stored at all
      if (wr && is_idx(idx, 6'(`IDX_AUX_OV_CHECK_EN)) && wb_sel_i[0]) begin
         new_aux = wb_dat_i[`AUX_EN_HI:0];
         clr_aux = ~new_aux;
      end
      state_next.ov_en = new_ov;
      state_next.uv_en = new_uv;
      state_next.aux_en = new_aux;

      clr.cell_adc_ov = clr_ov[`EN_CELL_HI:`EN_CELL_LO];
      clr.cell_cmp_ov = clr_ov[`EN_CELL_HI:`EN_CELL_LO];
      clr.cell_adc_uv = clr_uv[`EN_CELL_HI:`EN_CELL_LO];
      clr.cell_cmp_uv = clr_uv[`EN_CELL_HI:`EN_CELL_LO];
      clr.csa_ov = clr_ov[`EN_CSA_BIT];
      clr.csa_uv = clr_uv[`EN_CSA_BIT];
      clr.blk_ov = clr_ov[`EN_BLOCK_BIT];
      clr.blk_uv = clr_uv[`EN_BLOCK_BIT];
      clr.aux_adc = clr_aux;
      clr.aux_cmp = clr_aux;

      // a fault caught in the clearing cycle is kept
      state_next.alert = (state_reg.alert & ~clr) | hit;

      case (state_reg.scan)
         ST_IDLE: begin
            if (scan_start) begin
               // enables are frozen per scan, so a write lands next scan
               state_next.snap.cell_ov_check_en = state_reg.ov_en[`EN_CELL_HI:`EN_CELL_LO];
               state_next.snap.cell_uv_check_en = state_reg.uv_en[`EN_CELL_HI:`EN_CELL_LO];
               state_next.snap.current_amp_ov_check_en = state_reg.ov_en[`EN_CSA_BIT];
               state_next.snap.current_amp_uv_check_en = state_reg.uv_en[`EN_CSA_BIT];
               state_next.snap.block_ov_check_en = state_reg.ov_en[`EN_BLOCK_BIT];
               state_next.snap.block_uv_check_en = state_reg.uv_en[`EN_BLOCK_BIT];
               state_next.snap.aux_cold_check_en = state_reg.aux_en;
               state_next.scan = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (scan_end) begin
               state_next.scan = ST_IDLE;
               state_next.scan_done = 1'b1;
            end
         end
         default: state_next.scan = ST_IDLE;
      endcase

      state_next.rdata = state_reg.rdata;
      if (req && !wb_we_i) begin
         case (idx)
            6'(`IDX_OV_CHECK_EN): state_next.rdata = 32'(state_reg.ov_en);
            6'(`IDX_UV_CHECK_EN): state_next.rdata = 32'(state_reg.uv_en);
            // mode-masked enables still read back as written
            6'(`IDX_AUX_OV_CHECK_EN): state_next.rdata = 32'(state_reg.aux_en);
            6'(`IDX_CELL_ADC_ALERT): state_next.rdata =
               {2'h0, state_reg.alert.cell_adc_uv, 2'h0, state_reg.alert.cell_adc_ov};
            6'(`IDX_CELL_CMP_ALERT): state_next.rdata =
               {2'h0, state_reg.alert.cell_cmp_uv, 2'h0, state_reg.alert.cell_cmp_ov};
            6'(`IDX_CHAN_ALERT): state_next.rdata = 32'({state_reg.alert.aux_cmp,
               state_reg.alert.aux_adc, state_reg.alert.blk_uv, state_reg.alert.blk_ov,
               state_reg.alert.csa_uv, state_reg.alert.csa_ov});
            6'(`IDX_IRQ_STATUS): state_next.rdata = 32'(irq_stat);
            6'(`IDX_IRQ_MASK): state_next.rdata = 32'(irq_mask);
            default: state_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.ov_en <= `EN_RESET;
         state_reg.uv_en <= `EN_RESET;
         state_reg.aux_en <= `AUX_EN_RESET;
         state_reg.scan <= ST_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // fault events are new alerts only, so a held fault does not re-fire
   always_comb begin
      alerts_s fresh;
      fresh = hit & ~state_reg.alert;
      irq_events = '0;
      irq_events[`IRQ_CELL_OV] = |{fresh.cell_adc_ov, fresh.cell_cmp_ov};
      irq_events[`IRQ_CELL_UV] = |{fresh.cell_adc_uv, fresh.cell_cmp_uv};
      irq_events[`IRQ_CSA] = fresh.csa_ov | fresh.csa_uv;
      irq_events[`IRQ_BLOCK] = fresh.blk_ov | fresh.blk_uv;
      irq_events[`IRQ_AUX] = |{fresh.aux_adc, fresh.aux_cmp};
      irq_events[`IRQ_SCAN_DONE] = state_reg.scan_done;
   end

   irq_status u_irq (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .event_in(irq_events),
      .status_wr(irq_status_wr && wb_sel_i[0]),
      .mask_wr(irq_mask_wr && wb_sel_i[0]),
      .wdata(wb_dat_i[`IRQ_W-1:0]),
      .status(irq_stat),
      .mask(irq_mask),
      .irq(irq)
   );

   assign wb_ack_o = state_reg.ack;
   assign wb_dat_o = state_reg.rdata;
   assign alerts = state_reg.alert;
   assign scanning = (state_reg.scan == ST_SCAN);

endmodule

// file: tb/fault_check_enable_regs_asserts.sv
`timescale 1ns/1ps
`include "fault_check_defs.svh"

module fault_check_enable_regs_asserts
   import fault_check_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`ADDR_IDX_HI:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic scan_start,
   input wire logic scan_end,
   input wire meas_s meas,
   input wire thresh_s thr,
   input wire aux_cfg_s aux_cfg,
   input wire alerts_s alerts,
   input wire logic scanning,
   input wire logic irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire req = wb_cyc_i & wb_stb_i & ce;
   // a measurement set in the same cycle wins over the clear, so leave it out
   wire en_wr = req & wb_we_i & ~wb_ack_o & ~(scanning & meas.valid);
   wire [5:0] idx = wb_adr_i[7:2];

   property p_ack_answer; (req && !wb_ack_o) |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request left unanswered");
   property p_ack_pulse; (wb_ack_o && ce) |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; $rose(wb_ack_o) |-> $past(req); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_scan_enter; (!scanning && scan_start && ce) |=> scanning; endproperty
   a_scan_enter: assert property (p_scan_enter) else $error("scan not entered");
   property p_scan_leave; (scanning && scan_end && ce) |=> !scanning; endproperty
   a_scan_leave: assert property (p_scan_leave) else $error("scan not left");
   property p_no_alert_idle; (alerts & ~$past(alerts)) != '0 |-> $past(scanning); endproperty
   a_no_alert_idle: assert property (p_no_alert_idle) else $error("alert outside scan");
   property p_amp_cmp_ignored;
      (scanning && ce && meas.valid && meas.from_cmp && meas.kind == KIND_CSA
       && !alerts.csa_ov && !alerts.csa_uv) |=> (!alerts.csa_ov && !alerts.csa_uv);
   endproperty
   a_amp_cmp_ignored: assert property (p_amp_cmp_ignored) else $error("amp cmp used");
   property p_amp_ov_clear;
      (en_wr && idx == `IDX_OV_CHECK_EN && wb_sel_i[1] && !wb_dat_i[15]) |=> !alerts.csa_ov;
   endproperty
   a_amp_ov_clear: assert property (p_amp_ov_clear) else $error("amp alert kept");
   property p_block_clear;
      (en_wr && idx == `IDX_UV_CHECK_EN && wb_sel_i[1] && !wb_dat_i[14]) |=> !alerts.blk_uv;
   endproperty
   a_block_clear: assert property (p_block_clear) else $error("block alert kept");
   property p_cell_clear;
      (en_wr && idx == `IDX_OV_CHECK_EN && wb_sel_i[0] && !wb_dat_i[0])
      |=> (!alerts.cell_adc_ov[0] && !alerts.cell_cmp_ov[0]);
   endproperty
   a_cell_clear: assert property (p_cell_clear) else $error("cell alert kept");
   property p_aux_clear;
      (en_wr && idx == `IDX_AUX_OV_CHECK_EN && wb_sel_i[0] && !wb_dat_i[0])
      |=> (!alerts.aux_adc[0] && !alerts.aux_cmp[0]);
   endproperty
   a_aux_clear: assert property (p_aux_clear) else $error("aux alert kept");
endmodule

bind fault_check_enable_regs fault_check_enable_regs_asserts fault_check_enable_regs_asserts_i (
   .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_start(scan_start), .scan_end(scan_end),
   .meas(meas), .thr(thr), .aux_cfg(aux_cfg), .alerts(alerts), .scanning(scanning), .irq(irq)
);

// file: tb/fault_check_enable_regs_test.sv
`timescale 1ns/1ps
`include "fault_check_defs.svh"

module fault_check_enable_regs_test
   import fault_check_pkg::*;
;
   localparam logic [7:0] addr_ov = 8'h68;
   localparam logic [7:0] addr_uv = 8'h6c;
   localparam logic [7:0] addr_aux = 8'h70;
   localparam logic [7:0] addr_cadc = 8'h80;
   localparam logic [7:0] addr_ccmp = 8'h84;
   localparam logic [7:0] addr_chan = 8'h88;
   localparam logic [7:0] addr_ist = 8'h8c;
   localparam logic [7:0] addr_imsk = 8'h90;
   logic clk_sys, resetn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, scan_start, scan_end;
   logic scanning, irq;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   meas_s meas;
   thresh_s thr;
   aux_cfg_s aux_cfg;
   alerts_s alerts;
   int fails = 0;
   int total_checks = 0;

   fault_check_enable_regs fault_check_enable_regs_i (.clk_sys(clk_sys), .resetn(resetn),
      .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .scan_start(scan_start), .scan_end(scan_end), .meas(meas),
      .thr(thr), .aux_cfg(aux_cfg), .alerts(alerts), .scanning(scanning), .irq(irq));

   always #4 clk_sys = ~clk_sys;

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // seen is taken at the call, so outputs of the current edge need a delay first
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (n >= 20) begin
         fails++;
         $display("wrong value at %0t: no bus answer", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3);
      logic [31:0] q;
      xfer(1'b1, a, d, s, q);
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 4'hf, q);
      check(q, exp);
   endtask

   task automatic start_scan();
      @(posedge clk_sys);
      scan_start <= 1'b1;
      @(posedge clk_sys);
      scan_start <= 1'b0;
   endtask

   task automatic meas_one(input logic c, input meas_kind_e k, input logic [3:0] ch,
                           input logic [13:0] v);
      @(posedge clk_sys);
      meas <= {1'b1, c, k, ch, v};
      @(posedge clk_sys);
      meas <= '0;
   endtask

   // two extra edges so the scan-done event is already in the status
   task automatic finish_scan();
      @(posedge clk_sys);
      scan_end <= 1'b1;
      @(posedge clk_sys);
      scan_end <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      $display("wrong value at %0t: run too long", $time);
      close_out();
   end

   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, scan_start, scan_end} = '0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      meas = '0;
      aux_cfg = '0;
      thr = {14'h1000, 14'h0800, 14'h1100, 14'h0700, 14'h2000, 14'h0400, 14'h3000, 14'h0200,
             14'h1800, 14'h1a00, 14'h1900, 14'h1b00};
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_check(addr_ov, 32'h0);
      rd_check(addr_uv, 32'h0);
      rd_check(addr_aux, 32'h0);
      wr(addr_aux, 32'hffff);
      rd_check(addr_aux, 32'h000f);
      wr(addr_ov, 32'hffff, 4'h1);
      rd_check(addr_ov, 32'h00ff);
      wr(8'hfc, 32'hffff);
      rd_check(8'hfc, 32'h0);
      wr(addr_cadc, 32'hffffffff);
      rd_check(addr_cadc, 32'h0);
      $display("test registers done");
      wr(addr_ov, 32'h3fff);
      wr(addr_uv, 32'h3fff);
      start_scan();
      #1 check({31'h0, scanning}, 32'h1);
      meas_one(1'b0, KIND_CELL, 4'hd, 14'h1001);
      meas_one(1'b0, KIND_CELL, 4'h0, 14'h1000);
      meas_one(1'b1, KIND_CELL, 4'h2, 14'h1101);
      meas_one(1'b0, KIND_CELL, 4'h5, 14'h07ff);
      meas_one(1'b0, KIND_CELL, 4'he, 14'h3fff);
      finish_scan();
      check({31'h0, scanning}, 32'h0);
      rd_check(addr_cadc, 32'h0020_2000);
      rd_check(addr_ccmp, 32'h4);
      wr(addr_ov, 32'h1ffb);
      rd_check(addr_cadc, 32'h0020_0000);
      rd_check(addr_ccmp, 32'h0);
      wr(addr_uv, 32'h0);
      rd_check(addr_cadc, 32'h0);
      $display("test cells done");
      wr(addr_ov, 32'hc000);
      wr(addr_uv, 32'hc000);
      start_scan();
      meas_one(1'b1, KIND_CSA, 4'h0, 14'h0001);
      meas_one(1'b0, KIND_CSA, 4'h0, 14'h2001);
      meas_one(1'b0, KIND_BLOCK, 4'h0, 14'h3001);
      meas_one(1'b0, KIND_BLOCK, 4'h0, 14'h0001);
      finish_scan();
      rd_check(addr_chan, 32'h0d);
      wr(addr_ov, 32'h4000);
      rd_check(addr_chan, 32'h0c);
      wr(addr_uv, 32'h0);
      rd_check(addr_chan, 32'h04);
      wr(addr_ov, 32'h0);
      rd_check(addr_chan, 32'h0);
      $display("test amp and block done");
      aux_cfg <= {4'b0100, 4'b1000, 1'b0};
      wr(addr_aux, 32'hf, 4'h1);
      start_scan();
      meas_one(1'b0, KIND_AUX, 4'h0, 14'h1801);
      meas_one(1'b0, KIND_AUX, 4'h2, 14'h19ff);
      meas_one(1'b1, KIND_AUX, 4'h1, 14'h1901);
      meas_one(1'b0, KIND_AUX, 4'h3, 14'h3fff);
      finish_scan();
      rd_check(addr_chan, 32'h0210);
      aux_cfg <= {4'b0100, 4'b1000, 1'b1};
      start_scan();
      meas_one(1'b0, KIND_AUX, 4'h1, 14'h3fff);
      finish_scan();
      rd_check(addr_chan, 32'h0210);
      rd_check(addr_aux, 32'h000f);
      wr(addr_aux, 32'he, 4'h1);
      rd_check(addr_chan, 32'h0200);
      $display("test aux done");
      wr(addr_ist, 32'h3f);
      rd_check(addr_ist, 32'h0);
      wr(addr_imsk, 32'h20);
      start_scan();
      finish_scan();
      check({31'h0, irq}, 32'h1);
      rd_check(addr_ist, 32'h20);
      rd_check(addr_imsk, 32'h20);
      wr(addr_ist, 32'h20);
      check({31'h0, irq}, 32'h0);
      wr(addr_imsk, 32'h04);
      wr(addr_ov, 32'h8000);
      start_scan();
      meas_one(1'b0, KIND_CSA, 4'h0, 14'h2001);
      finish_scan();
      check({31'h0, irq}, 32'h1);
      rd_check(addr_ist, 32'h24);
      wr(addr_ov, 32'h0);
      wr(addr_ist, 32'h3f);
      check({31'h0, irq}, 32'h0);
      // a start pulse while frozen must not enter a scan
      ce <= 1'b0;
      start_scan();
      ce <= 1'b1;
      #1 check({31'h0, scanning}, 32'h0);
      $display("test interrupt done");
      start_scan();
      wr(addr_ov, 32'h1);
      meas_one(1'b0, KIND_CELL, 4'h0, 14'h1001);
      finish_scan();
      rd_check(addr_cadc, 32'h0);
      start_scan();
      meas_one(1'b0, KIND_CELL, 4'h0, 14'h1001);
      finish_scan();
      rd_check(addr_cadc, 32'h1);
      $display("test next scan done");
      close_out();
   end
endmodule
